// [verilog/odw_map.vh]
/*
  Register offsets, field positions, character codes and reset values
  for the display RAM write port and code decoder.
  Assumes inclusion by bare name from files under verilog/.
*/
`ifndef ODW_MAP_VH
`define ODW_MAP_VH

// Register offsets on the special function register bus
`define ODW_ATTRIBUTE_LATCH_ADDR   8'h98
`define ODW_CHARACTER_CODE_ADDR    8'h99
`define ODW_POINTER_ADDR           8'h9a

// Memory geometry
`define ODW_CODE_W                 6
`define ODW_ATTR_W                 4
`define ODW_WORD_W                 10
`define ODW_PTR_W                  7
`define ODW_DEPTH                  128

// Glyph geometry: scan lines per glyph and dots per line
`define ODW_GLYPH_LINES            18
`define ODW_GLYPH_DOTS             14
`define ODW_LINE_W                 5
`define ODW_GLYPH_ADDR_W           11

// Attribute register bit positions
`define ODW_ATTR_B_BIT             4
`define ODW_ATTR_SR_BIT            2
`define ODW_ATTR_D_BIT             1
`define ODW_ATTR_SH_BIT            0

// Writable attribute and pointer bits; all others reserved
`define ODW_ATTR_MASK              8'h17
`define ODW_PTR_MASK               8'h7f

// Reserved character codes
`define ODW_CODE_LINE_END          6'h3d
`define ODW_CODE_SPACE             6'h3c
`define ODW_CODE_BACKDROP          6'h3e
`define ODW_CODE_HALF_BACKDROP     6'h3f

// Decoded code kinds
`define ODW_KIND_GLYPH             3'h0
`define ODW_KIND_LINE_END          3'h1
`define ODW_KIND_SPACE             3'h2
`define ODW_KIND_BACKDROP          3'h3
`define ODW_KIND_HALF_BACKDROP     3'h4

// Reset values
`define ODW_ATTR_RESET             8'h00
`define ODW_PTR_RESET              7'h00
`define ODW_COLOUR_RESET           3'h0

`endif

// [verilog/odw_ram.v]
/*
  Simple dual-port character memory: one write port for the processor,
  one read port for display fetch with registered read data.
  Assumes both ports run on the same clock; no reset on the array.
*/
`timescale 1ns/10ps
`include "odw_map.vh"

module odw_ram (
  clock,
  wr_en,
  wr_addr,
  wr_data,
  rd_addr,
  rd_data
);
  input  wire                     clock;
  input  wire                     wr_en;
  input  wire [`ODW_PTR_W-1:0]    wr_addr;
  input  wire [`ODW_WORD_W-1:0]   wr_data;
  input  wire [`ODW_PTR_W-1:0]    rd_addr;
  output reg  [`ODW_WORD_W-1:0]   rd_data;

  reg [`ODW_WORD_W-1:0] mem [0:`ODW_DEPTH-1];

  // Independent write port, never blocked by the read side
  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port with registered output
  always @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end

endmodule // odw_ram

// [verilog/odw_write_port.v]
/*
  Processor write port into the on-screen-display character memory and
  decoder of the stored character and attribute codes for display fetch.
  Assumes the register bus and the display timing logic share this clock,
  so no input needs synchronising; the glyph generator is outside.
*/
`timescale 1ns/10ps
`include "odw_map.vh"

// What this block does
// - Each memory word holds a 6-bit character code and 4 attribute bits.
// - Glyph address is the stored code joined with the scan line in the row.
// - Each glyph is 18 scan lines of 14 dots.
// - 60 codes are glyphs; four reserved for line end and three spaces.
// - The processor cannot read the character memory contents.
// - Attribute writes only load the holding latch, never the memory.
// - Code writes store code plus held attribute at the pointer address.
// - Pointer is 7 bits in 6..0, bit 7 reserved, increments per code write.
// - Code register holds code in bits 5..0; bits 7 and 6 reserved.
// - Code writes accepted any time, dual-port memory removes conflicts.
// - 111101 line end, 111100 space, 111110 backdrop, 111111 half backdrop.
// - Line end with bit 4 set ends all rows for the field.
// - Line end, bit 4 clear, bit 2 set: next row is compact.
// - Line end, bit 4 clear, bit 1 set: next row double height and width.
// - Line end, bit 4 clear, bit 0 set: next row drawn with black border.
// - Backdrop codes take attribute bits 2..0 as the backdrop colour.
// - Plain backdrop code changes colour and enable at the cell left edge.
// - Bit 4 picks backdrop colour when set, incoming video when clear.
// - Ordinary codes take attribute bits 2..0 as glyph pixel colour.
// - Line end stops output until next scan line, then continues.
// - Half backdrop code changes colour and enable at mid cell.
// - Row end, compact, double and border latches clear at vertical start.
// - Backdrop colour survives vertical scans, changes only on backdrop codes.
module odw_write_port (
  clock,
  arst_n,
  sfr_addr,
  sfr_wdata,
  sfr_wr,
  sfr_rd,
  sfr_rdata,
  disp_addr,
  disp_fetch,
  scan_line,
  hsync_pulse,
  vscan_start,
  cell_midpoint,
  glyph_addr,
  glyph_valid,
  glyph_colour_bits,
  blank_cell,
  backdrop_enable,
  backdrop_colour_bits,
  row_wait,
  field_done,
  compact_row_flag,
  double_size_flag,
  black_border_flag
);
  input  wire                         clock;
  input  wire                         arst_n;
  input  wire [7:0]                   sfr_addr;
  input  wire [7:0]                   sfr_wdata;
  input  wire                         sfr_wr;
  input  wire                         sfr_rd;
  output reg  [7:0]                   sfr_rdata;
  input  wire [`ODW_PTR_W-1:0]        disp_addr;
  input  wire                         disp_fetch;
  input  wire [`ODW_LINE_W-1:0]       scan_line;
  input  wire                         hsync_pulse;
  input  wire                         vscan_start;
  input  wire                         cell_midpoint;
  output reg  [`ODW_GLYPH_ADDR_W-1:0] glyph_addr;
  output reg                          glyph_valid;
  output reg  [2:0]                   glyph_colour_bits;
  output reg                          blank_cell;
  output reg                          backdrop_enable;
  output reg  [2:0]                   backdrop_colour_bits;
  output reg                          row_wait;
  output reg                          field_done;
  output reg                          compact_row_flag;
  output reg                          double_size_flag;
  output reg                          black_border_flag;

  // Classify a stored code into glyph or one of the reserved kinds
  // Only codes with the top four bits all set are reserved
  function [2:0] code_kind;
    input [`ODW_CODE_W-1:0] code;
    begin
      case (code)
        `ODW_CODE_LINE_END:      code_kind = `ODW_KIND_LINE_END;
        `ODW_CODE_SPACE:         code_kind = `ODW_KIND_SPACE;
        `ODW_CODE_BACKDROP:      code_kind = `ODW_KIND_BACKDROP;
        `ODW_CODE_HALF_BACKDROP: code_kind = `ODW_KIND_HALF_BACKDROP;
        default:                 code_kind = `ODW_KIND_GLYPH;
      endcase
    end
  endfunction

  // Register bus decode
  wire                    hit_attr;
  wire                    hit_code;
  wire                    hit_ptr;
  wire                    attr_write;
  wire                    ptr_write;
  wire                    code_write;
  wire [`ODW_WORD_W-1:0]  write_word;
  wire [`ODW_WORD_W-1:0]  fetched_word;

  reg  [7:0]              attribute_latch;
  reg  [`ODW_PTR_W-1:0]   display_memory_pointer;

  assign hit_attr   = (sfr_addr == `ODW_ATTRIBUTE_LATCH_ADDR);
  assign hit_code   = (sfr_addr == `ODW_CHARACTER_CODE_ADDR);
  assign hit_ptr    = (sfr_addr == `ODW_POINTER_ADDR);
  assign attr_write = sfr_wr & hit_attr;
  assign ptr_write  = sfr_wr & hit_ptr;
  assign code_write = sfr_wr & hit_code;

  // Stored word: held attribute bits 4,2,1,0 above the 6-bit code
  assign write_word = {attribute_latch[`ODW_ATTR_B_BIT],
                       attribute_latch[`ODW_ATTR_SR_BIT],
                       attribute_latch[`ODW_ATTR_D_BIT],
                       attribute_latch[`ODW_ATTR_SH_BIT],
                       sfr_wdata[`ODW_CODE_W-1:0]};

  // Attribute holding latch; reserved bits dropped
  // Held across code writes so a run of characters shares one load
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      attribute_latch <= `ODW_ATTR_RESET;
    end else if (attr_write) begin
      attribute_latch <= sfr_wdata & `ODW_ATTR_MASK;
    end
  end

  // Pointer: software load, or increment after each code write
  // Load and code write never meet: the bus carries one address a cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      display_memory_pointer <= `ODW_PTR_RESET;
    end else if (ptr_write) begin
      display_memory_pointer <= sfr_wdata[`ODW_PTR_W-1:0];
    end else if (code_write) begin
      display_memory_pointer <= display_memory_pointer + 7'h01;
    end
  end

  // Read data: code register and memory never read back, unmapped reads zero
  // Data stands until the next read strobe
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (hit_attr) begin
        sfr_rdata <= attribute_latch;
      end else if (hit_ptr) begin
        sfr_rdata <= {1'b0, display_memory_pointer};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // Character memory; write port free of display reads
  // A write and a read of one address in a cycle return the old word
  odw_ram u_ram (
    .clock   (clock),
    .wr_en   (code_write),
    .wr_addr (display_memory_pointer),
    .wr_data (write_word),
    .rd_addr (disp_addr),
    .rd_data (fetched_word)
  );

  // Fetch pipeline: word arrives one cycle after fetch, with its scan line
  // Outputs below are registered two edges after the fetch strobe
  reg                     fetch_valid;
  reg [`ODW_LINE_W-1:0]   fetch_line;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fetch_valid <= 1'b0;
      fetch_line  <= {`ODW_LINE_W{1'b0}};
    end else begin
      fetch_valid <= disp_fetch;
      fetch_line  <= scan_line;
    end
  end

  // Fields of the fetched word
  wire [`ODW_CODE_W-1:0]  f_code;
  wire                    f_b;
  wire                    f_sr;
  wire                    f_d;
  wire                    f_sh;
  wire [2:0]              f_colour;
  wire [2:0]              f_kind;
  wire                    f_live;

  assign f_code   = fetched_word[`ODW_CODE_W-1:0];
  assign f_b      = fetched_word[9];
  assign f_sr     = fetched_word[8];
  assign f_d      = fetched_word[7];
  assign f_sh     = fetched_word[6];
  assign f_colour = fetched_word[8:6];
  assign f_kind   = code_kind(f_code);
  // Fetches ignored while a row end waits or the field is finished
  assign f_live   = fetch_valid & ~row_wait & ~field_done;

  // Kinds of a live fetch; glyph and line end are each used by more than one
  // process, so the decode is made once here
  wire                    take_glyph;
  wire                    take_line_end;
  wire                    take_backdrop;
  wire                    take_half;

  assign take_glyph    = f_live & (f_kind == `ODW_KIND_GLYPH);
  assign take_line_end = f_live & (f_kind == `ODW_KIND_LINE_END);
  assign take_backdrop = f_live & (f_kind == `ODW_KIND_BACKDROP);
  assign take_half     = f_live & (f_kind == `ODW_KIND_HALF_BACKDROP);

  // Glyph request and per-cell outputs
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      glyph_addr        <= {`ODW_GLYPH_ADDR_W{1'b0}};
      glyph_valid       <= 1'b0;
      glyph_colour_bits <= `ODW_COLOUR_RESET;
      blank_cell        <= 1'b0;
    end else begin
      glyph_valid <= take_glyph;
      blank_cell  <= f_live & ~take_glyph & ~take_line_end;
      if (take_glyph) begin
        glyph_addr        <= {f_code, fetch_line};
        glyph_colour_bits <= f_colour;
      end
    end
  end

  // Backdrop enable and colour; half-cell change waits for the midpoint
  // A plain backdrop code cancels a half-cell change still pending
  reg                     half_pending;
  reg                     half_b;
  reg [2:0]               half_colour;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      backdrop_enable      <= 1'b0;
      backdrop_colour_bits <= `ODW_COLOUR_RESET;
      half_pending         <= 1'b0;
      half_b               <= 1'b0;
      half_colour          <= `ODW_COLOUR_RESET;
    end else begin
      if (take_backdrop) begin
        backdrop_enable      <= f_b;
        backdrop_colour_bits <= f_colour;
        half_pending         <= 1'b0;
      end else if (take_half) begin
        half_pending <= 1'b1;
        half_b       <= f_b;
        half_colour  <= f_colour;
      end else if (half_pending && cell_midpoint) begin
        backdrop_enable      <= half_b;
        backdrop_colour_bits <= half_colour;
        half_pending         <= 1'b0;
      end else if (take_glyph) begin
        backdrop_enable <= f_b;
      end
      // Colour is not touched by vertical start, so one backdrop code
      // written at start-up can serve every field
    end
  end

  // Row control latches; vertical start clears them, colour excepted
  // Order of weight: vertical start, line end decode, scan line release
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      row_wait          <= 1'b0;
      field_done        <= 1'b0;
      compact_row_flag  <= 1'b0;
      double_size_flag  <= 1'b0;
      black_border_flag <= 1'b0;
    end else if (vscan_start) begin
      row_wait          <= 1'b0;
      field_done        <= 1'b0;
      compact_row_flag  <= 1'b0;
      double_size_flag  <= 1'b0;
      black_border_flag <= 1'b0;
    end else if (take_line_end) begin
      if (f_b) begin
        field_done <= 1'b1;
      end else begin
        row_wait          <= 1'b1;
        compact_row_flag  <= f_sr;
        double_size_flag  <= f_d;
        black_border_flag <= f_sh;
      end
    end else if (hsync_pulse) begin
      row_wait <= 1'b0;
    end
  end

endmodule // odw_write_port

// [test/odw_write_port_properties.sv]
/*
  Checker on the pins of the display RAM write port, bound at the foot.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module odw_write_port_properties (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        disp_fetch,
  input wire logic [4:0]  scan_line,
  input wire logic        hsync_pulse,
  input wire logic        vscan_start,
  input wire logic        cell_midpoint,
  input wire logic [10:0] glyph_addr,
  input wire logic        glyph_valid,
  input wire logic        blank_cell,
  input wire logic [2:0]  backdrop_colour_bits,
  input wire logic        row_wait,
  input wire logic        field_done,
  input wire logic        compact_row_flag,
  input wire logic        double_size_flag,
  input wire logic        black_border_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Register reads: memory unreadable, reserved bits read as zero
  AST_NO_RAM_READ: assert property (sfr_rd && sfr_addr == 8'h99 ##1 !sfr_rd |=>
    sfr_rdata == 8'h00) else $error("code register read not zero");
  AST_ATTR_RESERVED: assert property (sfr_rd && sfr_addr == 8'h98 ##1 !sfr_rd |=>
    (sfr_rdata & 8'he8) == 8'h00) else $error("attribute reserved bits set");
  AST_PTR_TOP_BIT: assert property (sfr_rd && sfr_addr == 8'h9a ##1 !sfr_rd |=>
    !sfr_rdata[7]) else $error("pointer bit 7 set");
  // Decode results tied to the fetch two cycles earlier
  AST_GLYPH_LINE: assert property (glyph_valid |->
    glyph_addr[4:0] == $past(scan_line, 2)) else $error("glyph scan line wrong");
  AST_GLYPH_CODE: assert property (glyph_valid |-> glyph_addr[10:7] != 4'hf &&
    !blank_cell && $past(disp_fetch, 2)) else $error("glyph from reserved code");
  // Row and field latches
  AST_ROW_RELEASE: assert property (row_wait && hsync_pulse && !vscan_start &&
    !$past(disp_fetch) |=> !row_wait) else $error("row wait not released");
  AST_VSCAN_CLEAR: assert property (vscan_start |=> !row_wait && !field_done &&
    !compact_row_flag && !double_size_flag && !black_border_flag) else $error("vscan clear");
  AST_COLOUR_KEPT: assert property (vscan_start && !$past(disp_fetch) &&
    !cell_midpoint |=> $stable(backdrop_colour_bits)) else $error("colour lost");
  AST_FIELD_QUIET: assert property (field_done [*3] |-> !glyph_valid && !blank_cell)
    else $error("output after field end");

  cover property (glyph_valid);
  cover property (row_wait && hsync_pulse);
  cover property (field_done && vscan_start);
endmodule // odw_write_port_properties

bind odw_write_port odw_write_port_properties u_props (.*);

// [test/odw_cpu_model.sv]
/*
  Processor core model on the special function register bus.
  Assumes one-cycle strobes taken on the rising clock edge.
*/
`timescale 1ns/10ps
module odw_cpu_model (
  input  wire logic       clock,
  input  wire logic [7:0] sfr_rdata,
  output logic      [7:0] sfr_addr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_wr,
  output logic            sfr_rd
);
  // Idle bus at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end

  // Write; released lines scrambled so stale values never match
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
    @(posedge clock);
    #1;
  endtask

  // Read; data taken one cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock);
    #1;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    @(posedge clock);
    #1;
    d = sfr_rdata;
  endtask

  // Attribute first so the code write picks it up
  task put_char(input logic new_attr, input logic [7:0] a, input logic [7:0] c);
    if (new_attr)
      wr(8'h98, a);
    wr(8'h99, c);
  endtask
endmodule // odw_cpu_model

// [test/test_osd_display_ram_write_port.sv]
/*
  Self-checking bench for the display RAM write port.
  Assumes the processor model and checker are compiled beforehand.
*/
`timescale 1ns/10ps
`include "odw_map.vh"
module test_osd_display_ram_write_port;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  wire  [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  wire         sfr_wr, sfr_rd;
  logic [6:0]  disp_addr = 7'h00;
  logic [4:0]  scan_line = 5'h00;
  logic        disp_fetch = 1'b0, hsync_pulse = 1'b0, vscan_start = 1'b0, cell_midpoint = 1'b0;
  wire  [10:0] glyph_addr;
  wire  [2:0]  glyph_colour_bits, backdrop_colour_bits;
  wire         glyph_valid, blank_cell, backdrop_enable, row_wait, field_done;
  wire         compact_row_flag, double_size_flag, black_border_flag;
  wire  [2:0]  row_flags;
  assign row_flags = {compact_row_flag, double_size_flag, black_border_flag};
  logic [9:0]  exp_mem [0:127];
  logic [7:0]  rd_val, attr, lat, code;
  logic [6:0]  ptr;
  logic [2:0]  bg = 3'h0;
  int          n_fail = 0, checks = 0, seed = 88043;

  always #20 clock = ~clock;

  odw_cpu_model u_odw_cpu_model (.*);
  odw_write_port u_odw_write_port (.*);

  // Verdict and end of run
  task summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task tick;
    @(posedge clock);
    #1;
  endtask

  task rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    u_odw_cpu_model.rd(a, rd_val);
    chk(n, {3'h0, e}, {3'h0, rd_val});
  endtask

  // Fetch strobe; returns in the cycle in which the decode pulses stand
  task fetch(input logic [6:0] a, input logic [4:0] l);
    disp_addr = a;
    scan_line = l;
    disp_fetch = 1'b1;
    tick;
    disp_fetch = 1'b0;
    tick;
  endtask

  function automatic logic [9:0] word(input logic [7:0] a, input logic [7:0] c);
    return {a[4], a[2:0], c[5:0]};
  endfunction

  // Fetch one stored word and compare its decode
  task check_word(input logic [6:0] a);
    logic [9:0] w;
    logic [4:0] l;
    w = exp_mem[a];
    l = 5'({$random(seed)} % 18);
    fetch(a, l);
    if (w[5:2] != 4'hf) begin
      chk("glyph_valid", 11'h1, {10'h0, glyph_valid});
      chk("glyph_addr", {w[5:0], l}, glyph_addr);
      chk("glyph_colour", {8'h0, w[8:6]}, {8'h0, glyph_colour_bits});
      chk("glyph_bg_en", {10'h0, w[9]}, {10'h0, backdrop_enable});
    end else begin
      chk("blank_cell", 11'h1, {10'h0, blank_cell});
      if (w[0]) begin
        chk("bg_before_mid", {8'h0, bg}, {8'h0, backdrop_colour_bits});
        cell_midpoint = 1'b1;
        tick;
        cell_midpoint = 1'b0;
        tick;
      end
      if (w[1]) begin
        bg = w[8:6];
        chk("bg_enable", {10'h0, w[9]}, {10'h0, backdrop_enable});
      end
      chk("bg_colour", {8'h0, bg}, {8'h0, backdrop_colour_bits});
    end
  endtask

  // Hang guard, about fifty times the expected run
  initial begin
    #400000;
    n_fail++;
    summarize;
  end

  initial begin
    repeat (16) @(posedge clock);
    #1 arst_n = 1'b1;
    rdchk("attr_reset", 8'h98, 8'h00);
    rdchk("ptr_reset", 8'h9a, 8'h00);
    u_odw_cpu_model.wr(8'h97, 8'hff);
    rdchk("unmapped", 8'h97, 8'h00);
    rdchk("code_read", 8'h99, 8'h00);
    u_odw_cpu_model.wr(8'h98, 8'hff);
    rdchk("attr_mask", 8'h98, 8'h17);
    u_odw_cpu_model.wr(8'h9a, 8'hff);
    rdchk("ptr_mask", 8'h9a, 8'h7f);
    u_odw_cpu_model.wr(8'h99, 8'hc5);
    exp_mem[127] = word(8'h17, 8'hc5);
    rdchk("ptr_wrap", 8'h9a, 8'h00);
    check_word(7'h7f);
    // Random run, attribute reused on every third code
    ptr = 7'h10;
    u_odw_cpu_model.wr(8'h9a, {1'b0, ptr});
    for (int i = 0; i < 24; i++) begin
      attr = $random(seed);
      code = $random(seed);
      if (i < 4)
        code[5:0] = {4'hf, 2'(i)};
      if (code[5:0] == `ODW_CODE_LINE_END)
        code[0] = 1'b0;
      if (i % 3 != 1)
        lat = attr;
      u_odw_cpu_model.put_char(i % 3 != 1, attr, code);
      exp_mem[ptr] = word(lat, code);
      ptr++;
    end
    rdchk("ptr_count", 8'h9a, {1'b0, ptr});
    u_odw_cpu_model.wr(8'h98, 8'h00);
    // Code write lands in the very cycle of a display fetch
    u_odw_cpu_model.wr(8'h9a, 8'h40);
    fork
      check_word(7'h10);
      u_odw_cpu_model.wr(8'h99, 8'h2a);
    join
    exp_mem[7'h40] = word(8'h00, 8'h2a);
    check_word(7'h40);
    for (int i = 16; i < 40; i++)
      check_word(7'(i));
    // Line ends: flags, wait for the scan line, end of field
    u_odw_cpu_model.wr(8'h9a, 8'h00);
    u_odw_cpu_model.put_char(1'b1, 8'h05, 8'h3d);
    u_odw_cpu_model.put_char(1'b1, 8'h10, 8'h3d);
    u_odw_cpu_model.put_char(1'b1, 8'h05, 8'h02);
    fetch(7'h00, 5'h00);
    chk("row_wait", 11'h1, {10'h0, row_wait});
    chk("flags", 11'h5, {8'h0, row_flags});
    fetch(7'h02, 5'h03);
    chk("refused", 11'h0, {10'h0, glyph_valid});
    hsync_pulse = 1'b1;
    tick;
    hsync_pulse = 1'b0;
    tick;
    chk("row_go", 11'h0, {10'h0, row_wait});
    fetch(7'h02, 5'h03);
    chk("glyph_after", {6'h02, 5'h03}, glyph_addr);
    fetch(7'h01, 5'h00);
    chk("field_done", 11'h1, {10'h0, field_done});
    chk("flags_kept", 11'h5, {8'h0, row_flags});
    fetch(7'h02, 5'h00);
    chk("field_quiet", 11'h0, {10'h0, glyph_valid});
    vscan_start = 1'b1;
    tick;
    vscan_start = 1'b0;
    tick;
    chk("vscan", 11'h0, {6'h0, row_wait, field_done, row_flags});
    chk("bg_kept", {8'h0, bg}, {8'h0, backdrop_colour_bits});
    // Second line end with other flag bits, so no two flags can be swapped
    u_odw_cpu_model.put_char(1'b1, 8'h03, 8'h3d);
    fetch(7'h03, 5'h00);
    chk("flags_next", 11'h3, {8'h0, row_flags});
    summarize;
  end
endmodule // test_osd_display_ram_write_port
